/* verilog/camrs_pkg.sv */
// Purpose: Shared constants
// Assumes: 32-bit AXI4-Lite, registers 16 bits wide in the low half
// Notes: Offsets are byte addresses
package camrs_pkg;
   localparam int ADDR_W = 8;
   // Register map
   localparam logic [7:0] OFS_MSEL = 8'h00;
   localparam logic [7:0] OFS_STD0 = 8'h04;
   localparam logic [7:0] OFS_STD1 = 8'h08;
   localparam logic [7:0] OFS_STD2 = 8'h0C;
   localparam logic [7:0] OFS_EXT0 = 8'h10;
   localparam logic [7:0] OFS_EXT1 = 8'h14;
   localparam logic [7:0] OFS_EXT2 = 8'h18;
   localparam logic [7:0] OFS_FULL_LO = 8'h1C;
   localparam logic [7:0] OFS_FULL_HI = 8'h20;
   localparam logic [7:0] OFS_OVF_LO = 8'h24;
   localparam logic [7:0] OFS_OVF_HI = 8'h28;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
   // Reset values
   localparam logic [15:0] MSEL_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [31:0] FLAG_RST = 32'h0000_0000;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // Standard word bits 4 and 2 absent
   localparam logic [15:0] STD_IMPL = 16'hFFEB;
   // Mask source codes
   localparam logic [1:0] SRC_M0 = 2'h0;
   localparam logic [1:0] SRC_M1 = 2'h1;
   localparam logic [1:0] SRC_M2 = 2'h2;
   localparam logic [1:0] SRC_NONE = 2'h3;
   // Field positions
   localparam int STD_LSB = 5;
   localparam int MODE_BIT = 3;
   localparam int NFILT = 8;
   localparam logic [3:0] FIRST_FILT = 4'h8;
   localparam int NBUF = 32;
   localparam int IRQ_STORE = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_HIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Source field of upper filter f
   function automatic logic [1:0] src_of(input logic [15:0] sel, input int f);
      return sel[2*f +: 2];
   endfunction

   // Byte lanes written
   function automatic logic [15:0] lane_mask(input logic [3:0] strb);
      return {{8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // Index of lowest set bit, zero when none
   function automatic logic [2:0] first_set(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NFILT - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction
endpackage

/* verilog/camrs_match.sv */
// Purpose: Masked compare of one filter
// Assumes: Mask chosen upstream; all-ones mask with mode set means no mask
// Notes: Purely combinational
`timescale 1ns/1ns
module camrs_match (
   input wire logic [10:0] flt_std,
   input wire logic [17:0] flt_ext,
   input wire logic flt_ext_en,
   input wire logic [10:0] msk_std,
   input wire logic [17:0] msk_ext,
   input wire logic msk_mode,
   input wire logic [10:0] msg_std,
   input wire logic [17:0] msg_ext,
   input wire logic msg_is_ext,
   output logic hit
);
   logic std_eq;
   logic ext_eq;
   logic type_ok;

   // Included bits must equal, others are don't care
   assign std_eq = ((flt_std ^ msg_std) & msk_std) == 11'h000;
   assign ext_eq = ((flt_ext ^ msg_ext) & msk_ext) == 18'h0_0000;
   // Strict mode: frame type must follow the filter's extended enable
   assign type_ok = !msk_mode || (flt_ext_en == msg_is_ext);
   // Either type passes on its own identifier width otherwise
   assign hit = type_ok && std_eq && (!msg_is_ext || ext_eq);
endmodule

/* verilog/camrs_axil.sv */
// Purpose: AXI4-Lite slave
// Assumes: One write and one read in flight at most
// Notes: Write executes one cycle after both halves held
`timescale 1ns/1ns
module camrs_axil (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] wr_addr,
   output logic [15:0] wr_data,
   output logic [3:0] wr_strb,
   output logic wr_en,
   input wire logic wr_mapped,
   input wire logic [15:0] rd_word,
   input wire logic rd_mapped
);
   logic wr_go;

   // Both halves held and no answer pending
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && !wr_en;

   ////////////////////////////////////////////////////////////////////////////
   // Write channels, taken in either order
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= camrs_pkg::RESP_OKAY;
         wr_addr <= 8'h00;
         wr_data <= 16'h0000;
         wr_strb <= 4'h0;
         wr_en <= 1'b0;
      end else begin
         wr_en <= wr_go;
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata[15:0];
            wr_strb <= s_axi_wstrb;
         end
         // Response stands with the write pulse
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? camrs_pkg::RESP_OKAY : camrs_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel, data captured at the address handshake
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= camrs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_word};
         s_axi_rresp <= rd_mapped ? camrs_pkg::RESP_OKAY : camrs_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

/* verilog/camrs_top.sv */
// Purpose: Mask selection, acceptance masks and rx buffer status flags
// Assumes: Filter values and buffer targets come from outside logic
// Notes: Registers over AXI4-Lite, one level interrupt
//
// Contract
// - Two-bit source field picks mask 0, 1, 2, or no mask.
// - Filter 15 at bits 15-14 down to filter 8 at 1-0, reset zero.
// - Three masks; standard bits 15-5, one compares, zero ignores.
// - Standard word bits 1-0 mask extended identifier bits 17-16.
// - Separate 16-bit word per mask covers extended bits 15-0.
// - Mode bit 3 set: identifier type must equal filter's extended enable.
// - Mode bit clear: either type passes when masked identifier equals.
// - Full flag set on fill; buffers 0-15 low word, 16-31 high.
// - Flags readable, cleared by writing zero, one leaves them, reset zero.
// - Store into a full buffer sets that buffer's overflow flag.
// - Standard word bits 4 and 2 read zero; masks undefined at reset.
// - Each included identifier bit must equal the filter bit.
// - Extended enable one picks extended, zero standard, in strict mode.
`timescale 1ns/1ns
module camrs_top (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [87:0] filter_standard_identifier,
   input wire logic [143:0] filter_extended_identifier,
   input wire logic [7:0] filter_extended_enable,
   input wire logic rx_valid,
   input wire logic [10:0] rx_standard_identifier,
   input wire logic [17:0] rx_extended_identifier,
   input wire logic rx_extended_frame,
   input wire logic store_valid,
   input wire logic [4:0] store_index,
   output logic rx_hit,
   output logic [3:0] rx_hit_filter,
   output logic [7:0] rx_hit_map,
   output logic store_write,
   output logic [4:0] store_buffer,
   output logic store_overflow,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] wr_addr;
   logic [15:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_en;
   logic wr_mapped;
   logic rd_mapped;
   logic [15:0] rd_word;
   logic [15:0] wmask;
   logic [15:0] mask_sel;
   logic [15:0] std_word [3];
   logic [15:0] ext_word [3];
   logic [15:0] std_pick [4];
   logic [15:0] ext_pick [4];
   logic [31:0] full;
   logic [31:0] ovf;
   logic [31:0] next_full;
   logic [31:0] next_ovf;
   logic [31:0] keep_full;
   logic [31:0] keep_ovf;
   logic [31:0] store_bit;
   logic store_ok;
   logic store_clash;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [2:0] next_irq_stat;
   logic [2:0] irq_event;
   logic [2:0] irq_clr;
   logic [7:0] hits;
   logic any_hit;
   logic wa_msel;
   logic wa_full_lo;
   logic wa_full_hi;
   logic wa_ovf_lo;
   logic wa_ovf_hi;
   logic wa_irq_stat;
   logic wa_irq_mask;
   logic [2:0] wa_std;
   logic [2:0] wa_ext;
   logic ra_msel;
   logic ra_full_lo;
   logic ra_full_hi;
   logic ra_ovf_lo;
   logic ra_ovf_hi;
   logic ra_irq_stat;
   logic ra_irq_mask;
   logic [2:0] ra_std;
   logic [2:0] ra_ext;
   logic [15:0] rd_std;
   logic [15:0] rd_ext;

   ////////////////////////////////////////////////////////////////////////////
   // Bus front end
   camrs_axil u_axil (
      .clock(clock),
      .arst_n(arst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_en(wr_en),
      .wr_mapped(wr_mapped),
      .rd_word(rd_word),
      .rd_mapped(rd_mapped)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Write address decode
   assign wmask = camrs_pkg::lane_mask(wr_strb);
   assign wa_msel = wr_addr == camrs_pkg::OFS_MSEL;
   assign wa_std[0] = wr_addr == camrs_pkg::OFS_STD0;
   assign wa_std[1] = wr_addr == camrs_pkg::OFS_STD1;
   assign wa_std[2] = wr_addr == camrs_pkg::OFS_STD2;
   assign wa_ext[0] = wr_addr == camrs_pkg::OFS_EXT0;
   assign wa_ext[1] = wr_addr == camrs_pkg::OFS_EXT1;
   assign wa_ext[2] = wr_addr == camrs_pkg::OFS_EXT2;
   assign wa_full_lo = wr_addr == camrs_pkg::OFS_FULL_LO;
   assign wa_full_hi = wr_addr == camrs_pkg::OFS_FULL_HI;
   assign wa_ovf_lo = wr_addr == camrs_pkg::OFS_OVF_LO;
   assign wa_ovf_hi = wr_addr == camrs_pkg::OFS_OVF_HI;
   assign wa_irq_stat = wr_addr == camrs_pkg::OFS_IRQ_STAT;
   assign wa_irq_mask = wr_addr == camrs_pkg::OFS_IRQ_MASK;
   assign wr_mapped = wa_msel | (|wa_std) | (|wa_ext) | wa_full_lo | wa_full_hi
      | wa_ovf_lo | wa_ovf_hi | wa_irq_stat | wa_irq_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Read address decode and data select
   assign ra_msel = s_axi_araddr == camrs_pkg::OFS_MSEL;
   assign ra_std[0] = s_axi_araddr == camrs_pkg::OFS_STD0;
   assign ra_std[1] = s_axi_araddr == camrs_pkg::OFS_STD1;
   assign ra_std[2] = s_axi_araddr == camrs_pkg::OFS_STD2;
   assign ra_ext[0] = s_axi_araddr == camrs_pkg::OFS_EXT0;
   assign ra_ext[1] = s_axi_araddr == camrs_pkg::OFS_EXT1;
   assign ra_ext[2] = s_axi_araddr == camrs_pkg::OFS_EXT2;
   assign ra_full_lo = s_axi_araddr == camrs_pkg::OFS_FULL_LO;
   assign ra_full_hi = s_axi_araddr == camrs_pkg::OFS_FULL_HI;
   assign ra_ovf_lo = s_axi_araddr == camrs_pkg::OFS_OVF_LO;
   assign ra_ovf_hi = s_axi_araddr == camrs_pkg::OFS_OVF_HI;
   assign ra_irq_stat = s_axi_araddr == camrs_pkg::OFS_IRQ_STAT;
   assign ra_irq_mask = s_axi_araddr == camrs_pkg::OFS_IRQ_MASK;
   assign rd_mapped = ra_msel | (|ra_std) | (|ra_ext) | ra_full_lo | ra_full_hi
      | ra_ovf_lo | ra_ovf_hi | ra_irq_stat | ra_irq_mask;
   assign rd_std = ({16{ra_std[0]}} & std_word[0]) | ({16{ra_std[1]}} & std_word[1])
      | ({16{ra_std[2]}} & std_word[2]);
   assign rd_ext = ({16{ra_ext[0]}} & ext_word[0]) | ({16{ra_ext[1]}} & ext_word[1])
      | ({16{ra_ext[2]}} & ext_word[2]);
   // Unmapped reads return zero
   assign rd_word = ({16{ra_msel}} & mask_sel) | rd_std | rd_ext
      | ({16{ra_full_lo}} & full[15:0])
      | ({16{ra_full_hi}} & full[31:16])
      | ({16{ra_ovf_lo}} & ovf[15:0])
      | ({16{ra_ovf_hi}} & ovf[31:16])
      | ({16{ra_irq_stat}} & {13'h0000, irq_stat})
      | ({16{ra_irq_mask}} & {13'h0000, irq_mask});

   ////////////////////////////////////////////////////////////////////////////
   // Mask source selector, one field per upper filter
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mask_sel <= camrs_pkg::MSEL_RST;
      end else if (wr_en && wa_msel) begin
         mask_sel <= (mask_sel & ~wmask) | (wr_data & wmask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Three masks; reset to zero, software must not rely on it
   for (genvar m = 0; m < 3; m++) begin : g_mask
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            std_word[m] <= camrs_pkg::MASK_RST;
            ext_word[m] <= camrs_pkg::MASK_RST;
         end else if (wr_en) begin
            if (wa_std[m]) begin
               // Absent bits never store a one, so they read zero
               std_word[m] <= ((std_word[m] & ~wmask) | (wr_data & wmask))
                  & camrs_pkg::STD_IMPL;
            end
            if (wa_ext[m]) begin
               ext_word[m] <= (ext_word[m] & ~wmask) | (wr_data & wmask);
            end
         end
      end
      assign std_pick[m] = std_word[m];
      assign ext_pick[m] = ext_word[m];
   end

   // No mask: every bit compared and type must match exactly
   assign std_pick[3] = 16'hFFFF;
   assign ext_pick[3] = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////////
   // Per-filter mask pick and compare for filters 8 to 15
   for (genvar f = 0; f < camrs_pkg::NFILT; f++) begin : g_filt
      logic [1:0] src;
      logic [15:0] s_word;
      logic [15:0] e_word;
      assign src = camrs_pkg::src_of(mask_sel, f);
      assign s_word = std_pick[src];
      assign e_word = ext_pick[src];
      camrs_match u_match (
         .flt_std(filter_standard_identifier[11*f +: 11]),
         .flt_ext(filter_extended_identifier[18*f +: 18]),
         .flt_ext_en(filter_extended_enable[f]),
         .msk_std(s_word[15:camrs_pkg::STD_LSB]),
         .msk_ext({s_word[1:0], e_word}),
         .msk_mode(s_word[camrs_pkg::MODE_BIT]),
         .msg_std(rx_standard_identifier),
         .msg_ext(rx_extended_identifier),
         .msg_is_ext(rx_extended_frame),
         .hit(hits[f])
      );
   end

   assign any_hit = |hits;

   ////////////////////////////////////////////////////////////////////////////
   // Acceptance result, one cycle after the message is offered
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_hit <= 1'b0;
         rx_hit_map <= 8'h00;
         rx_hit_filter <= 4'h0;
      end else begin
         rx_hit <= rx_valid && any_hit;
         rx_hit_map <= rx_valid ? hits : 8'h00;
         // Lowest numbered matching filter wins
         rx_hit_filter <= camrs_pkg::FIRST_FILT + {1'b0, camrs_pkg::first_set(hits)};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer store request against the full flags
   assign store_bit = 32'h0000_0001 << store_index;
   assign store_clash = store_valid && full[store_index];
   assign store_ok = store_valid && !full[store_index];

   // Write zero clears, write one keeps; untouched lanes keep too
   assign keep_full[15:0] = (wr_en && wa_full_lo) ? (wr_data | ~wmask) : 16'hFFFF;
   assign keep_full[31:16] = (wr_en && wa_full_hi) ? (wr_data | ~wmask) : 16'hFFFF;
   assign keep_ovf[15:0] = (wr_en && wa_ovf_lo) ? (wr_data | ~wmask) : 16'hFFFF;
   assign keep_ovf[31:16] = (wr_en && wa_ovf_hi) ? (wr_data | ~wmask) : 16'hFFFF;

   // Hardware set wins over a same-cycle clear
   assign next_full = (full & keep_full) | (store_ok ? store_bit : 32'h0000_0000);
   assign next_ovf = (ovf & keep_ovf) | (store_clash ? store_bit : 32'h0000_0000);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         full <= camrs_pkg::FLAG_RST;
         ovf <= camrs_pkg::FLAG_RST;
      end else begin
         full <= next_full;
         ovf <= next_ovf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write grant: a clash drops the message so the old contents survive
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         store_write <= 1'b0;
         store_overflow <= 1'b0;
         store_buffer <= 5'h00;
      end else begin
         store_write <= store_ok;
         store_overflow <= store_clash;
         store_buffer <= store_index;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, write one to clear, set wins
   assign irq_event[camrs_pkg::IRQ_STORE] = store_ok;
   assign irq_event[camrs_pkg::IRQ_OVF] = store_clash;
   assign irq_event[camrs_pkg::IRQ_HIT] = rx_valid && any_hit;
   assign irq_clr = (wr_en && wa_irq_stat) ? (wr_data[2:0] & wmask[2:0]) : 3'h0;
   assign next_irq_stat = (irq_stat & ~irq_clr) | irq_event;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat <= camrs_pkg::IRQ_RST;
         irq_mask <= camrs_pkg::IRQ_RST;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (wr_en && wa_irq_mask) begin
            irq_mask <= (irq_mask & ~wmask[2:0]) | (wr_data[2:0] & wmask[2:0]);
         end
         // Taken from next status
         irq <= |(next_irq_stat & irq_mask);
      end
   end
endmodule

/* testbench/camrs_top_assertions.sv */
// Purpose: Port checks
// Assumes: One clock, async active-low reset
// Notes: Bound to every camrs_top
`timescale 1ns/1ns
module camrs_chk (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic rx_valid,
   input wire logic store_valid,
   input wire logic [4:0] store_index,
   input wire logic rx_hit,
   input wire logic [3:0] rx_hit_filter,
   input wire logic [7:0] rx_hit_map,
   input wire logic store_write,
   input wire logic [4:0] store_buffer,
   input wire logic store_overflow,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Filter results
   AST_HIT_ANY: assert property (rx_hit == (rx_hit_map != 8'h00))
      else $error("hit vs map");
   AST_NO_MSG: assert property (!rx_valid |=> rx_hit_map == 8'h00)
      else $error("stray map");
   // Lowest match
   AST_LOWEST: assert property (rx_hit |-> rx_hit_filter[3] && rx_hit_map[rx_hit_filter[2:0]]
      && (rx_hit_map & ((8'h01 << rx_hit_filter[2:0]) - 8'h01)) == 8'h00)
      else $error("not lowest");
   // Store outcomes
   AST_ONE_OUTCOME: assert property (store_valid |=> store_write != store_overflow)
      else $error("no outcome");
   AST_IDLE_STORE: assert property (!store_valid |=> !store_write && !store_overflow)
      else $error("stray outcome");
   AST_BUF_ECHO: assert property (store_valid |=> store_buffer == $past(store_index))
      else $error("bad index");
   // Refill of a full buffer
   AST_REFILL: assert property (store_valid ##1 (store_valid
      && store_index == $past(store_index)) |=> store_overflow && !store_write)
      else $error("refill taken");
   AST_RD_HIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper half set");
endmodule
bind camrs_top camrs_chk camrs_chk_i (.clock(clock), .arst_n(arst_n), .rx_valid(rx_valid),
   .store_valid(store_valid), .store_index(store_index), .rx_hit(rx_hit),
   .rx_hit_filter(rx_hit_filter), .rx_hit_map(rx_hit_map), .store_write(store_write),
   .store_buffer(store_buffer), .store_overflow(store_overflow),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

/* testbench/camrs_can_src.sv */
// Purpose: Receive path model
// Assumes: Tasks are entered at a rising edge
// Notes: Idle fields show inverted values
`timescale 1ns/1ns
module camrs_can_src (
   input wire logic clock,
   output logic rx_valid,
   output logic [10:0] rx_sid,
   output logic [17:0] rx_eid,
   output logic rx_ext,
   output logic store_valid,
   output logic [4:0] store_index
);
   // Quiet at time zero
   initial begin
      rx_valid = 1'b0;
      store_valid = 1'b0;
      {rx_sid, rx_eid, rx_ext, store_index} = '0;
   end
   // One message offered for one cycle
   task send(input logic [10:0] s, input logic [17:0] e, input logic x);
      rx_valid <= 1'b1;
      {rx_sid, rx_eid, rx_ext} <= {s, e, x};
      @(posedge clock);
      rx_valid <= 1'b0;
      {rx_sid, rx_eid, rx_ext} <= ~{s, e, x};
   endtask
   // n back-to-back stores into one buffer
   task store(input logic [4:0] i, input int n);
      repeat (n) begin
         store_valid <= 1'b1;
         store_index <= i;
         @(posedge clock);
      end
      store_valid <= 1'b0;
      store_index <= ~i;
      @(posedge clock);
   endtask
endmodule

/* testbench/camrs_top_test.sv */
// Purpose: Bench of the block
// Assumes: Any bus latency
// Notes: All filters hold id 0x123
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module camrs_top_test;
   typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e; logic [1:0] r;} camrs_row_t;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq, hit, s_wr, s_ovf, rxv, rxx, stv;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata;
   logic [3:0] hit_f;
   logic [7:0] hit_map;
   logic [4:0] s_buf, st_i;
   logic [10:0] standard_identifier;
   logic [17:0] extended_identifier;
   logic [15:0] got;
   int errors = 0, n_checks = 0;
   camrs_row_t rows [7] = '{'{camrs_pkg::OFS_MSEL, 16'hE4E4, 16'hE4E4, 2'h0},
      '{camrs_pkg::OFS_STD0, 16'hFFF4, 16'hFFE0, 2'h0}, '{camrs_pkg::OFS_STD1, 16'h0014, 16'h0000, 2'h0},
      '{camrs_pkg::OFS_STD2, 16'hFF00, 16'hFF00, 2'h0}, '{camrs_pkg::OFS_EXT1, 16'hA5A5, 16'hA5A5, 2'h0},
      '{camrs_pkg::OFS_FULL_LO, 16'hFFFF, 16'h0000, 2'h0}, '{8'h3C, 16'h1111, 16'h0000, 2'h2}};
   ////////////////////////////////////////////////////////////////////////////////
   camrs_top camrs_top_i (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .filter_standard_identifier({8{11'h123}}),
      .filter_extended_identifier(144'h0), .filter_extended_enable(8'h00), .rx_valid(rxv),
      .rx_standard_identifier(standard_identifier), .rx_extended_identifier(extended_identifier), .rx_extended_frame(rxx),
      .store_valid(stv), .store_index(st_i), .rx_hit(hit), .rx_hit_filter(hit_f),
      .rx_hit_map(hit_map), .store_write(s_wr), .store_buffer(s_buf), .store_overflow(s_ovf),
      .irq(irq));
   camrs_can_src camrs_can_src_i (.clock(clock), .rx_valid(rxv), .rx_sid(standard_identifier), .rx_eid(extended_identifier),
      .rx_ext(rxx), .store_valid(stv), .store_index(st_i));
   ////////////////////////////////////////////////////////////////////////////////
   // Bus write
   task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge clock); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clock); while (!bvalid);
      r = bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      d = rdata[15:0];
      r = rresp;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      rd(a, got, resp);
      `CHK(got, e)
   endtask
   // Result one cycle on
   task automatic msg(input logic [10:0] s, input logic [17:0] e, input logic x,
         input logic [7:0] m, input logic [3:0] f);
      camrs_can_src_i.send(s, e, x);
      #1;
      `CHK(hit_map, m)
      `CHK(hit_f, f)
      @(posedge clock);
   endtask
   task complete_run;
      $display("checks %0d bad %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 clock = ~clock;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      complete_run;
   end
   initial begin
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      bready <= 1'b1;
      rready <= 1'b1;
      @(posedge clock);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, resp);
         `CHK(resp, rows[i].r)
         rd(rows[i].a, got, resp);
         `CHK(got, rows[i].e)
         `CHK(resp, rows[i].r)
      end
      $display("register table done");
      msg(11'h124, 18'h0_0000, 1'b0, 8'h66, 4'h9);
      wr(camrs_pkg::OFS_STD1, 16'h0008, resp);
      msg(11'h124, 18'h0_0000, 1'b1, 8'h44, 4'hA);
      msg(11'h124, 18'h0_0000, 1'b0, 8'h66, 4'h9);
      wr(camrs_pkg::OFS_EXT2, 16'h0001, resp);
      msg(11'h124, 18'h0_0001, 1'b1, 8'h00, 4'h8);
      msg(11'h124, 18'h1_0000, 1'b1, 8'h44, 4'hA);
      wr(camrs_pkg::OFS_STD2, 16'hFF01, resp);
      msg(11'h124, 18'h1_0000, 1'b1, 8'h00, 4'h8);
      $display("filter test done");
      camrs_can_src_i.store(5'h05, 2);
      camrs_can_src_i.store(5'h14, 1);
      chk_rd(camrs_pkg::OFS_FULL_LO, 16'h0020);
      chk_rd(camrs_pkg::OFS_OVF_LO, 16'h0020);
      chk_rd(camrs_pkg::OFS_FULL_HI, 16'h0010);
      chk_rd(camrs_pkg::OFS_OVF_HI, 16'h0000);
      chk_rd(camrs_pkg::OFS_IRQ_STAT, 16'h0007);
      `CHK(irq, 1'b0)
      wr(camrs_pkg::OFS_IRQ_MASK, 16'h0001, resp);
      @(posedge clock) #1 `CHK(irq, 1'b1)
      wr(camrs_pkg::OFS_IRQ_STAT, 16'h0001, resp);
      #1 `CHK(irq, 1'b0)
      chk_rd(camrs_pkg::OFS_IRQ_STAT, 16'h0006);
      wr(camrs_pkg::OFS_FULL_LO, 16'hFFDF, resp);
      chk_rd(camrs_pkg::OFS_FULL_LO, 16'h0000);
      chk_rd(camrs_pkg::OFS_OVF_LO, 16'h0020);
      $display("store test done");
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      chk_rd(camrs_pkg::OFS_MSEL, 16'h0000);
      chk_rd(camrs_pkg::OFS_OVF_LO, 16'h0000);
      $display("reset test done");
      complete_run;
   end
endmodule
